// File: rtl/csit_map.svh
// Purpose: Register offsets, bit positions and reset values of the channel status/interrupt tree
// Assumes: Nine-bit register address space, byte-wide registers
// Notes: Definitions only
`ifndef CSIT_MAP_SVH
`define CSIT_MAP_SVH

`define CSIT_OFS_PIN_LEVEL 9'h041
`define CSIT_OFS_TOP_SUM 9'h042
`define CSIT_OFS_GLOBAL_FN_PENDING_SUM 9'h043
`define CSIT_OFS_OC_SUM 9'h045
`define CSIT_OFS_PLL_SUM 9'h046
`define CSIT_OFS_PLL_LOCK 9'h048
`define CSIT_OFS_MEAS_HIGH 9'h04B
`define CSIT_OFS_ADJ_STAT 9'h04D

`define CSIT_TOP_GLOBAL_FN_PENDING_BIT 6
`define CSIT_TOP_OC_BIT 5
`define CSIT_TOP_PLL_BIT 2
`define CSIT_TOP_IE_BIT 1
`define CSIT_TOP_INT_BIT 0

`define CSIT_GLOBAL_FN_PENDING_BOOT_BIT 7
`define CSIT_GLOBAL_FN_PENDING_PA_BIT 1
`define CSIT_GLOBAL_FN_PENDING_MAB_BIT 0

`define CSIT_LK2IE_BIT 6
`define CSIT_LK2L_BIT 5
`define CSIT_LK2_BIT 4
`define CSIT_LKIE_BIT 2
`define CSIT_LKL_BIT 1
`define CSIT_LK_BIT 0

`define CSIT_MEAS_OVF_BIT 6
`define CSIT_MEAS_MEASURE_READY_EN_BIT 5
`define CSIT_MEAS_RDY_BIT 4
`define CSIT_MEAS_BUSY_BIT 3

`define CSIT_ADJ_TOP_BIT 7
`define CSIT_ADJ_IE_BIT 3
`define CSIT_ADJ_FLAG_BIT 2
`define CSIT_ADJ_BUSY_BIT 1
`define CSIT_ADJ_ARMED_BIT 0

`define CSIT_RST_BYTE 8'h00
`define CSIT_RST_ADJ_FLAG 1'b1
`define CSIT_ADJ_TOP_VAL 1'b1

`endif

// File: rtl/csit_pkg.sv
// Purpose: Shared types and helpers of the channel status/interrupt tree
// Assumes: Nothing beyond the map header
// Notes: Flag helper gives the set priority over the clear
package csit_pkg;
  typedef logic [7:0] csit_byte_t;
  typedef logic [8:0] csit_addr_t;

  // Latched flag update; an event in the clearing cycle survives
  function automatic logic csit_flag_next(input logic flag, input logic set, input logic clr);
    return set | (flag & ~clr);
  endfunction : csit_flag_next
endpackage : csit_pkg

// File: rtl/csit_lock_if.sv
// Purpose: Carrier between the top and the lock-flag block
// Assumes: Single clock, synchronised lock levels
// Notes: Top drives the request side, lock block the status side
`timescale 1ns/1ps
interface csit_lock_if;
  import csit_pkg::*;
  logic lock_primary;
  logic lock_secondary;
  logic wr;
  csit_byte_t wdata;
  csit_byte_t status;
  logic pending;
  modport top (output lock_primary, output lock_secondary, output wr, output wdata,
               input status, input pending);
  modport lock (input lock_primary, input lock_secondary, input wr, input wdata,
                output status, output pending);
endinterface : csit_lock_if

// File: rtl/csit_lock_flags.sv
// Purpose: PLL lock status register with change-latched flags and enables
// Assumes: Lock levels already synchronised to clk_i
// Notes: Change flags clear on a written one only
`timescale 1ns/1ps
`include "csit_map.svh"
module csit_lock_flags
  import csit_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  csit_lock_if.lock lk
);
  logic prev_p_r, prev_p_nxt;
  logic prev_s_r, prev_s_nxt;
  logic chg_p_r, chg_p_nxt;
  logic chg_s_r, chg_s_nxt;
  logic en_p_r, en_p_nxt;
  logic en_s_r, en_s_nxt;

  always_comb begin
    prev_p_nxt = lk.lock_primary;
    prev_s_nxt = lk.lock_secondary;
    // Any change of level, rising or falling, latches
    chg_p_nxt = csit_flag_next(chg_p_r, prev_p_r ^ lk.lock_primary,
                               lk.wr & lk.wdata[`CSIT_LKL_BIT]);
    chg_s_nxt = csit_flag_next(chg_s_r, prev_s_r ^ lk.lock_secondary,
                               lk.wr & lk.wdata[`CSIT_LK2L_BIT]);
    en_p_nxt = lk.wr ? lk.wdata[`CSIT_LKIE_BIT] : en_p_r;
    en_s_nxt = lk.wr ? lk.wdata[`CSIT_LK2IE_BIT] : en_s_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_p_r <= 1'b0;
      prev_s_r <= 1'b0;
      chg_p_r <= 1'b0;
      chg_s_r <= 1'b0;
      en_p_r <= 1'b0;
      en_s_r <= 1'b0;
    end else begin
      prev_p_r <= prev_p_nxt;
      prev_s_r <= prev_s_nxt;
      chg_p_r <= chg_p_nxt;
      chg_s_r <= chg_s_nxt;
      en_p_r <= en_p_nxt;
      en_s_r <= en_s_nxt;
    end
  end

  always_comb begin
    lk.status = `CSIT_RST_BYTE;
    lk.status[`CSIT_LK_BIT] = lk.lock_primary;
    lk.status[`CSIT_LKL_BIT] = chg_p_r;
    lk.status[`CSIT_LKIE_BIT] = en_p_r;
    lk.status[`CSIT_LK2_BIT] = lk.lock_secondary;
    lk.status[`CSIT_LK2L_BIT] = chg_s_r;
    lk.status[`CSIT_LK2IE_BIT] = en_s_r;
  end

  assign lk.pending = (chg_p_r & en_p_r) | (chg_s_r & en_s_r);
endmodule : csit_lock_flags

// File: rtl/csit_top.sv
// Purpose: Per-channel status registers and two-level interrupt summary tree
// Assumes: Register strobes come from the host serial port logic on clk_i
// Notes: Read data is registered and valid the cycle after the read strobe
//
// Contract
// - Pin level register shows live sampled pins 3..0, no inversion applied.
// - Top summary bit 6 is OR of global-function summary bits 1 and 0 (not boot bit 7), read-only.
// - Top summary bit 5 is OR of output clock summary bits, read-only.
// - Top summary bit 2 is OR of PLL summary bits, read-only.
// - Writable master enable at top bit 1; zero blocks the interrupt bit.
// - Interrupt bit equals OR of bits 6, 5, 2 ANDed with master enable.
// - A general-purpose pin can be set to follow the interrupt bit.
// - Boot-done flag cleared by channel reset, set when boot configuration ends.
// - Global bit 1 is any enabled latched phase-adjust flag.
// - Global bit 0 is any enabled latched phase-measurement flag.
// - Output clock summary bits 0..2 follow enabled flags of outputs 1..3.
// - PLL summary bit 0 is any enabled latched PLL flag.
// - Secondary lock change flag sets on any change, clears on written one.
// - Primary lock change flag sets on any change, clears on written one.
// - Enable bit 6 gates secondary lock change into the summary.
// - Enable bit 2 gates primary lock change into the summary.
// - Primary lock status is live: one locked, zero not locked.
// - Measurement overflow flag latches when a measurement ends with overflow.
// - Measurement-ready flag latches on new result; enable bit 5 gates it.
// - Phase-adjust finished flag latches on completion, clears on written one.
`timescale 1ns/1ps
`include "csit_map.svh"
module csit_top
  import csit_pkg::*;
#(
  parameter int PIN_COUNT = 4,
  parameter int OC_COUNT = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire csit_addr_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire csit_byte_t reg_wdata_i,
  input wire logic reg_rd_i,
  output csit_byte_t reg_rdata_o,
  input wire logic [PIN_COUNT-1:0] gpio_pin_i,
  input wire logic [PIN_COUNT-1:0] gpio_follow_irq_i,
  output logic [PIN_COUNT-1:0] gpio_pin_o,
  output logic [PIN_COUNT-1:0] gpio_pin_oe_n_o,
  input wire logic lock_primary_i,
  input wire logic lock_secondary_i,
  input wire logic boot_done_i,
  input wire logic adjust_done_i,
  input wire logic adjust_busy_i,
  input wire logic adjust_armed_i,
  input wire logic meas_done_i,
  input wire logic meas_overflow_i,
  input wire logic meas_busy_i,
  input wire logic [2:0] meas_high_i,
  input wire logic [OC_COUNT-1:0] out_clock_pending_i,
  output logic irq_o
);
  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Pin and lock levels come from outside this clock domain
  logic [PIN_COUNT-1:0] pin_meta_r, pin_meta_nxt;
  logic [PIN_COUNT-1:0] pin_sync_r, pin_sync_nxt;
  logic [1:0] lock_meta_r, lock_meta_nxt;
  logic [1:0] lock_sync_r, lock_sync_nxt;

  always_comb begin
    pin_meta_nxt = gpio_pin_i;
    pin_sync_nxt = pin_meta_r;
    lock_meta_nxt = {lock_secondary_i, lock_primary_i};
    lock_sync_nxt = lock_meta_r;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      lock_meta_r <= 2'h0;
      lock_sync_r <= 2'h0;
    end else begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
      lock_meta_r <= lock_meta_nxt;
      lock_sync_r <= lock_sync_nxt;
    end
  end

  // Write decode
  logic wr_top;
  logic wr_lock;
  logic wr_meas;
  logic wr_adj;

  assign wr_top = reg_wr_i & (reg_addr_i == `CSIT_OFS_TOP_SUM);
  assign wr_lock = reg_wr_i & (reg_addr_i == `CSIT_OFS_PLL_LOCK);
  assign wr_meas = reg_wr_i & (reg_addr_i == `CSIT_OFS_MEAS_HIGH);
  assign wr_adj = reg_wr_i & (reg_addr_i == `CSIT_OFS_ADJ_STAT);

  // PLL lock flags live in their own block
  csit_lock_if lk_if ();

  assign lk_if.lock_primary = lock_sync_r[0];
  assign lk_if.lock_secondary = lock_sync_r[1];
  assign lk_if.wr = wr_lock;
  assign lk_if.wdata = reg_wdata_i;

  csit_lock_flags u_lock (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .lk(lk_if.lock)
  );

  // Latched flags and writable enables
  logic ie_r, ie_nxt;
  logic boot_r, boot_nxt;
  logic ovf_r, ovf_nxt;
  logic rdy_r, rdy_nxt;
  logic rdy_en_r, rdy_en_nxt;
  logic adj_r, adj_nxt;
  logic adj_en_r, adj_en_nxt;

  always_comb begin
    ie_nxt = wr_top ? reg_wdata_i[`CSIT_TOP_IE_BIT] : ie_r;
    // Cleared only by reset; no software clear exists
    boot_nxt = boot_r | boot_done_i;
    ovf_nxt = csit_flag_next(ovf_r, meas_done_i & meas_overflow_i,
                             wr_meas & reg_wdata_i[`CSIT_MEAS_OVF_BIT]);
    rdy_nxt = csit_flag_next(rdy_r, meas_done_i,
                             wr_meas & reg_wdata_i[`CSIT_MEAS_RDY_BIT]);
    rdy_en_nxt = wr_meas ? reg_wdata_i[`CSIT_MEAS_MEASURE_READY_EN_BIT] : rdy_en_r;
    adj_nxt = csit_flag_next(adj_r, adjust_done_i,
                             wr_adj & reg_wdata_i[`CSIT_ADJ_FLAG_BIT]);
    adj_en_nxt = wr_adj ? reg_wdata_i[`CSIT_ADJ_IE_BIT] : adj_en_r;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ie_r <= 1'b0;
      boot_r <= 1'b0;
      ovf_r <= 1'b0;
      rdy_r <= 1'b0;
      rdy_en_r <= 1'b0;
      adj_r <= `CSIT_RST_ADJ_FLAG;
      adj_en_r <= 1'b0;
    end else begin
      ie_r <= ie_nxt;
      boot_r <= boot_nxt;
      ovf_r <= ovf_nxt;
      rdy_r <= rdy_nxt;
      rdy_en_r <= rdy_en_nxt;
      adj_r <= adj_nxt;
      adj_en_r <= adj_en_nxt;
    end
  end

  // Summary tree, purely combinational so it tracks sources each cycle
  logic phase_adjust_pending;
  logic phase_measure_pending;
  logic global_fn_pending;
  logic out_clock_pending;
  logic pll_pending;
  logic top_int;

  assign phase_adjust_pending = adj_r & adj_en_r;
  // Overflow carries no enable, so only the ready flag can raise the summary
  assign phase_measure_pending = rdy_r & rdy_en_r;
  assign global_fn_pending = phase_adjust_pending | phase_measure_pending;
  assign out_clock_pending = |out_clock_pending_i;
  assign pll_pending = lk_if.pending;
  assign top_int = (global_fn_pending | out_clock_pending | pll_pending) & ie_r;

  assign irq_o = top_int;

  // Register images
  csit_byte_t top_img;
  csit_byte_t global_fn_pending_img;
  csit_byte_t meas_img;
  csit_byte_t adj_img;

  always_comb begin
    top_img = `CSIT_RST_BYTE;
    top_img[`CSIT_TOP_GLOBAL_FN_PENDING_BIT] = global_fn_pending;
    top_img[`CSIT_TOP_OC_BIT] = out_clock_pending;
    top_img[`CSIT_TOP_PLL_BIT] = pll_pending;
    top_img[`CSIT_TOP_IE_BIT] = ie_r;
    top_img[`CSIT_TOP_INT_BIT] = top_int;
    global_fn_pending_img = `CSIT_RST_BYTE;
    global_fn_pending_img[`CSIT_GLOBAL_FN_PENDING_BOOT_BIT] = boot_r;
    global_fn_pending_img[`CSIT_GLOBAL_FN_PENDING_PA_BIT] = phase_adjust_pending;
    global_fn_pending_img[`CSIT_GLOBAL_FN_PENDING_MAB_BIT] = phase_measure_pending;
    meas_img = `CSIT_RST_BYTE;
    meas_img[`CSIT_MEAS_OVF_BIT] = ovf_r;
    meas_img[`CSIT_MEAS_MEASURE_READY_EN_BIT] = rdy_en_r;
    meas_img[`CSIT_MEAS_RDY_BIT] = rdy_r;
    meas_img[`CSIT_MEAS_BUSY_BIT] = meas_busy_i;
    meas_img[2:0] = meas_high_i;
    adj_img = `CSIT_RST_BYTE;
    adj_img[`CSIT_ADJ_TOP_BIT] = `CSIT_ADJ_TOP_VAL;
    adj_img[`CSIT_ADJ_IE_BIT] = adj_en_r;
    adj_img[`CSIT_ADJ_FLAG_BIT] = adj_r;
    adj_img[`CSIT_ADJ_BUSY_BIT] = adjust_busy_i;
    adj_img[`CSIT_ADJ_ARMED_BIT] = adjust_armed_i;
  end

  // Read path; unmapped addresses read zero
  csit_byte_t rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `CSIT_OFS_PIN_LEVEL: rdata_nxt = {{(8-PIN_COUNT){1'b0}}, pin_sync_r};
        `CSIT_OFS_TOP_SUM: rdata_nxt = top_img;
        `CSIT_OFS_GLOBAL_FN_PENDING_SUM: rdata_nxt = global_fn_pending_img;
        `CSIT_OFS_OC_SUM: rdata_nxt = {{(8-OC_COUNT){1'b0}}, out_clock_pending_i};
        `CSIT_OFS_PLL_SUM: rdata_nxt = {7'h00, pll_pending};
        `CSIT_OFS_PLL_LOCK: rdata_nxt = lk_if.status;
        `CSIT_OFS_MEAS_HIGH: rdata_nxt = meas_img;
        `CSIT_OFS_ADJ_STAT: rdata_nxt = adj_img;
        default: rdata_nxt = `CSIT_RST_BYTE;
      endcase
    end
  end

  // Pins following the interrupt bit; registered so the pad sees a clean level
  logic [PIN_COUNT-1:0] pin_out_r, pin_out_nxt;
  logic [PIN_COUNT-1:0] pin_oe_n_r, pin_oe_n_nxt;

  always_comb begin
    pin_out_nxt = {PIN_COUNT{top_int}} & gpio_follow_irq_i;
    pin_oe_n_nxt = ~gpio_follow_irq_i;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `CSIT_RST_BYTE;
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
    end else begin
      rdata_r <= rdata_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign gpio_pin_o = pin_out_r;
  assign gpio_pin_oe_n_o = pin_oe_n_r;
endmodule : csit_top

// File: dv/csit_top_assertions.sv
// Purpose: Port-level checker of the channel status/interrupt tree
// Assumes: Read data is valid one cycle after the read strobe
// Notes: Pin level and output clock pending reads are checked only when the inputs have settled
`timescale 1ns/1ps
module csit_top_assertions
  import csit_pkg::*;
#(
  parameter int PIN_COUNT = 4,
  parameter int OC_COUNT = 3
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire csit_addr_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire csit_byte_t reg_wdata_i,
  input wire logic reg_rd_i,
  input wire csit_byte_t reg_rdata_o,
  input wire logic [PIN_COUNT-1:0] gpio_pin_i,
  input wire logic [PIN_COUNT-1:0] gpio_follow_irq_i,
  input wire logic [PIN_COUNT-1:0] gpio_pin_o,
  input wire logic [PIN_COUNT-1:0] gpio_pin_oe_n_o,
  input wire logic [OC_COUNT-1:0] out_clock_pending_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_pin_follow: assert property (gpio_pin_o == $past({PIN_COUNT{irq_o}} & gpio_follow_irq_i))
    else $error("pin does not follow the interrupt bit");
  // Three quiet edges cover the two-flop reset release and the pad flop, also after a mid-run reset
  a_pin_enable: assert property ($past(nrst_i, 3) && $past(nrst_i, 2) && $past(nrst_i) |->
    gpio_pin_oe_n_o == ~$past(gpio_follow_irq_i))
    else $error("pin enable wrong");
  a_top_form: assert property (reg_rd_i && reg_addr_i == 9'h042 |=>
    reg_rdata_o[0] == ((reg_rdata_o[6] | reg_rdata_o[5] | reg_rdata_o[2]) & reg_rdata_o[1]))
    else $error("interrupt bit not the masked summary");
  a_irq_read: assert property (reg_rd_i && reg_addr_i == 9'h042 |=> reg_rdata_o[0] == $past(irq_o))
    else $error("read interrupt bit differs from output");
  a_irq_mask: assert property (reg_wr_i && reg_addr_i == 9'h042 && !reg_wdata_i[1] |=> !irq_o)
    else $error("interrupt raised with master enable off");
  a_oc_sum: assert property (reg_rd_i && reg_addr_i == 9'h045 && $stable(out_clock_pending_i) |=>
    reg_rdata_o == 8'($past(out_clock_pending_i))) else $error("output clock summary wrong");
  a_oc_top: assert property (reg_rd_i && reg_addr_i == 9'h042 && $stable(out_clock_pending_i) |=>
    reg_rdata_o[5] == |$past(out_clock_pending_i)) else $error("output clock top bit wrong");
  a_pin_read: assert property (reg_rd_i && reg_addr_i == 9'h041 && $stable(gpio_pin_i) &&
    $past(gpio_pin_i, 2) == gpio_pin_i && $past(gpio_pin_i, 3) == gpio_pin_i |=>
    reg_rdata_o == 8'($past(gpio_pin_i))) else $error("pin level read wrong");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 9'h044 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  c_lock_read: cover property (reg_rd_i && reg_addr_i == 9'h048);
  c_irq_high: cover property (irq_o);
  c_pin_rise: cover property ($rose(gpio_pin_o[0]));
endmodule : csit_top_assertions

bind csit_top csit_top_assertions #(.PIN_COUNT(PIN_COUNT), .OC_COUNT(OC_COUNT)) u_csit_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gpio_pin_i(gpio_pin_i), .gpio_follow_irq_i(gpio_follow_irq_i),
  .gpio_pin_o(gpio_pin_o), .gpio_pin_oe_n_o(gpio_pin_oe_n_o), .out_clock_pending_i(out_clock_pending_i),
  .irq_o(irq_o));

// File: dv/csit_tb.sv
// Purpose: Self-checking bench of the channel status/interrupt tree
// Assumes: Plain register strobe port, answer one cycle after the read
// Notes: Fixed waits cover the two-flop input synchronisers
`timescale 1ns/1ps
module testbench;
  import csit_pkg::*;
  typedef struct packed {logic [3:0] pin; logic [2:0] ocp; csit_addr_t a; csit_byte_t e;} csit_row_s;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic irq_o;
  csit_addr_t reg_addr_i = 9'h000;
  csit_byte_t reg_wdata_i = 8'h00;
  csit_byte_t reg_rdata_o;
  logic [3:0] pins = 4'h0, follow = 4'h3, pin_o, oe_n;
  logic lk1 = 1'b0, lk2 = 1'b0, boot = 1'b0, adone = 1'b0, meas = 1'b0, ovf = 1'b0;
  logic [2:0] ocp = 3'h0;
  int n_mismatch = 0;
  int n_tests = 0;
  // Reset-value row comes first, before any write
  csit_row_s rows [12] = '{'{4'h0, 3'h0, 9'h04D, 8'h84}, '{4'h5, 3'h0, 9'h041, 8'h05}, '{4'hA, 3'h0, 9'h041, 8'h0A},
    '{4'hF, 3'h1, 9'h045, 8'h01}, '{4'h0, 3'h2, 9'h045, 8'h02}, '{4'h0, 3'h4, 9'h045, 8'h04},
    '{4'h0, 3'h4, 9'h042, 8'h20}, '{4'h0, 3'h0, 9'h044, 8'h00}, '{4'h0, 3'h0, 9'h043, 8'h00},
    '{4'hB, 3'h0, 9'h04B, 8'h0B}, '{4'h3, 3'h0, 9'h04D, 8'h87},
    '{4'h0, 3'h0, 9'h048, 8'h00}};

  // Live busy, armed and measurement bits borrow the pin vector so the rows can set them
  csit_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gpio_pin_i(pins),
    .gpio_follow_irq_i(follow), .gpio_pin_o(pin_o), .gpio_pin_oe_n_o(oe_n), .lock_primary_i(lk1),
    .lock_secondary_i(lk2), .boot_done_i(boot), .adjust_done_i(adone), .adjust_busy_i(pins[1]),
    .adjust_armed_i(pins[0]), .meas_done_i(meas), .meas_overflow_i(ovf), .meas_busy_i(pins[3]),
    .meas_high_i(pins[2:0]), .out_clock_pending_i(ocp), .irq_o(irq_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic rd(input csit_addr_t a, input csit_byte_t e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask : rd

  task automatic wr(input csit_addr_t a, input csit_byte_t d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Bounds the whole run, so a hang still reaches the verdict
  initial begin
    cyc(5000);
    n_mismatch++;
    stop_test();
  end

  initial begin
    cyc(20);
    nrst_i <= 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      @(posedge clk_i);
      pins <= rows[i].pin;
      ocp <= rows[i].ocp;
      cyc(5);
      rd(rows[i].a, rows[i].e);
    end
    @(posedge clk_i);
    ocp <= 3'h1;
    wr(9'h042, 8'h02);
    rd(9'h042, 8'h23);
    chk({4'h0, pin_o}, 8'h03);
    chk({4'h0, oe_n}, 8'h0C);
    wr(9'h042, 8'hFD);
    rd(9'h042, 8'h20);
    chk({7'h00, irq_o}, 8'h00);
    @(posedge clk_i);
    ocp <= 3'h0;
    lk1 <= 1'b1;
    cyc(4);
    rd(9'h048, 8'h03);
    rd(9'h046, 8'h00);
    wr(9'h048, 8'h04);
    rd(9'h046, 8'h01);
    rd(9'h042, 8'h04);
    wr(9'h048, 8'h06);
    rd(9'h048, 8'h05);
    @(posedge clk_i);
    lk1 <= 1'b0;
    lk2 <= 1'b1;
    cyc(4);
    rd(9'h048, 8'h36);
    wr(9'h048, 8'h42);
    rd(9'h048, 8'h70);
    rd(9'h046, 8'h01);
    wr(9'h048, 8'h20);
    rd(9'h048, 8'h10);
    rd(9'h046, 8'h00);
    @(posedge clk_i);
    lk1 <= 1'b1;
    cyc(4);
    rd(9'h048, 8'h13);
    @(posedge clk_i);
    meas <= 1'b1;
    ovf <= 1'b1;
    @(posedge clk_i);
    meas <= 1'b0;
    ovf <= 1'b0;
    rd(9'h04B, 8'h50);
    rd(9'h043, 8'h00);
    wr(9'h04B, 8'h20);
    rd(9'h043, 8'h01);
    rd(9'h042, 8'h40);
    wr(9'h04B, 8'h70);
    rd(9'h04B, 8'h20);
    wr(9'h04D, 8'h08);
    rd(9'h043, 8'h02);
    wr(9'h04D, 8'h0C);
    rd(9'h04D, 8'h88);
    @(posedge clk_i);
    adone <= 1'b1;
    boot <= 1'b1;
    @(posedge clk_i);
    adone <= 1'b0;
    boot <= 1'b0;
    rd(9'h043, 8'h82);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    cyc(3);
    chk(reg_rdata_o, 8'h00);
    nrst_i <= 1'b1;
    cyc(4);
    rd(9'h043, 8'h00);
    stop_test();
  end
endmodule : testbench
